/* verilog/card_socket_ctl.sv */
/*
  Socket-side strobe sequencer for a 16-bit memory or I/O card with DMA.
  Assumes the host holds cmd steady while start is high, until done pulses.
*/
`timescale 1ns/10ps
module card_socket_ctl (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Host request side
  input wire logic start,
  input wire logic [2:0] cmd,
  input wire logic lastItem,
  input wire logic ioMode,
  input wire logic cardResetReq,
  output logic busy,
  output logic done,
  output logic wideXfer,
  output logic byteHigh,
  output logic cardReady,
  output logic cardIrq,
  output logic writeProtect,
  output logic dmaRequest,
  output logic [1:0] cardVoltage,
  // Card pins
  output logic oe_n,
  output logic we_n,
  output logic reg_n,
  output logic io_read_strobe_n,
  output logic io_write_strobe_n,
  output logic cardReset,
  input wire logic wait_n,
  input wire logic card_irq_n,
  input wire logic wp_pin,
  input wire logic voltage_sense_a,
  input wire logic voltage_sense_b
);
  import card_ctl_pkg::*;
  ctl_t r;
  ctl_t next_r;
  logic [1:0] vsSync1;

  always_comb begin
    next_r = r;
    next_r.done = 1'b0;
    next_r.waitSync = {r.waitSync[0], ~wait_n};
    next_r.readySync = {r.readySync[0], card_irq_n};
    next_r.wpSync = {r.wpSync[0], wp_pin};
    next_r.vsense = vsSync1;
    case (r.state)
      ST_IDLE: begin
        if (start && !cardResetReq) begin
          next_r.state = ST_SETUP;
          next_r.cmd = cmd;
          next_r.last = lastItem;
          next_r.secondByte = 1'b0;
          next_r.count = 4'h1;
          // Attribute/I/O/DMA select low before strobe
          next_r.reg_n = (cmd == CMD_MEM_RD || cmd == CMD_MEM_WR) ? ~ioMode : 1'b0;
        end
      end
      ST_SETUP: begin
        next_r.state = ST_STROBE;
        next_r.count = STROBE_CYC;
        // Wide-port flag sampled at strobe start for I/O
        next_r.wide = r.wpSync[1];
        next_r.byteHigh = r.secondByte;
        case (r.cmd)
          CMD_MEM_RD: next_r.oe_n = 1'b0;
          CMD_MEM_WR: next_r.we_n = 1'b0;
          CMD_IO_RD: next_r.io_read_strobe_n_n = 1'b0;
          CMD_IO_WR: next_r.io_write_strobe_n_n = 1'b0;
          // Card-to-host is the DMA write: output enable carries terminal count
          CMD_DMA_TO_HOST: begin
            next_r.io_read_strobe_n_n = 1'b0;
            next_r.oe_n = ~r.last;
          end
          // Host-to-card is the DMA read: write enable carries terminal count
          CMD_DMA_TO_CARD: begin
            next_r.io_write_strobe_n_n = 1'b0;
            next_r.we_n = ~r.last;
          end
          // Unknown commands finish with done and no strobe
          default: next_r.state = ST_DONE;
        endcase
      end
      ST_STROBE: begin
        // Minimum strobe width first, then hold while the card asks for wait
        if (r.count > 4'h1) begin
          next_r.count = r.count - 4'h1;
        end else if (!r.waitSync[1]) begin
          next_r.oe_n = 1'b1;
          next_r.we_n = 1'b1;
          next_r.io_read_strobe_n_n = 1'b1;
          next_r.io_write_strobe_n_n = 1'b1;
          // Narrow port: run a second strobe for the high byte
          if ((r.cmd == CMD_IO_RD || r.cmd == CMD_IO_WR) && !r.wide && !r.secondByte) begin
            next_r.secondByte = 1'b1;
            next_r.state = ST_SETUP;
          end else begin
            next_r.state = ST_DONE;
          end
        end
      end
      // Select released together with the done pulse
      ST_DONE: begin
        next_r.reg_n = 1'b1;
        next_r.done = 1'b1;
        next_r.state = ST_IDLE;
      end
      default: next_r.state = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      r <= '0;
      r.oe_n <= 1'b1;
      r.we_n <= 1'b1;
      r.reg_n <= 1'b1;
      r.io_read_strobe_n_n <= 1'b1;
      r.io_write_strobe_n_n <= 1'b1;
      r.readySync <= 2'h3;
      r.vsense <= VS_5V;
      vsSync1 <= VS_5V;
    end else begin
      r <= next_r;
      vsSync1 <= {voltage_sense_b, voltage_sense_a};
    end
  end

  assign busy = (r.state != ST_IDLE);
  assign done = r.done;
  assign wideXfer = r.wide;
  assign byteHigh = r.byteHigh;
  assign oe_n = r.oe_n;
  assign we_n = r.we_n;
  assign reg_n = r.reg_n;
  assign io_read_strobe_n = r.io_read_strobe_n_n;
  assign io_write_strobe_n = r.io_write_strobe_n_n;
  assign cardReset = cardResetReq;
  assign cardReady = !ioMode && r.readySync[1];
  assign cardIrq = ioMode && !r.readySync[1];
  assign writeProtect = !ioMode && r.wpSync[1];
  assign dmaRequest = r.wpSync[1];
  assign cardVoltage = r.vsense;


  // Strobe and select checks
  a_oe_read: assert property (@(posedge ref_clk) disable iff (!resetn)
    (r.state == ST_SETUP && r.cmd == CMD_MEM_RD) |=> !oe_n && !we_n == 1'b0)
    else $error("oe not low on memory read");
  a_wait_hold: assert property (@(posedge ref_clk) disable iff (!resetn)
    (r.state == ST_STROBE && r.waitSync[1]) |=> r.state == ST_STROBE)
    else $error("cycle ended during wait");
  a_strobe_width: assert property (@(posedge ref_clk) disable iff (!resetn)
    $fell(we_n) && r.cmd == CMD_MEM_WR |-> !we_n [*3])
    else $error("write strobe too short");
  a_reg_common: assert property (@(posedge ref_clk) disable iff (!resetn)
    (!oe_n && r.cmd == CMD_MEM_RD && !ioMode) |-> reg_n)
    else $error("attribute select low on common access");
  a_dma_acknowledge_io: assert property (@(posedge ref_clk) disable iff (!resetn)
    (!io_read_strobe_n || !io_write_strobe_n) |-> !reg_n)
    else $error("io strobe without select");
  a_tc_read: assert property (@(posedge ref_clk) disable iff (!resetn)
    (!we_n && r.cmd == CMD_DMA_TO_CARD) |-> r.last && !io_write_strobe_n)
    else $error("terminal count wrong on dma read");
  a_tc_write: assert property (@(posedge ref_clk) disable iff (!resetn)
    (!oe_n && r.cmd == CMD_DMA_TO_HOST) |-> r.last && !io_read_strobe_n)
    else $error("terminal count wrong on dma write");
  a_byte_pair: assert property (@(posedge ref_clk) disable iff (!resetn)
    (r.state == ST_DONE && (r.cmd == CMD_IO_RD || r.cmd == CMD_IO_WR)) |-> r.wide || r.secondByte)
    else $error("narrow port missed second byte");

  // Memory write strobes write enable only
  a_wr_strobe: assert property (@(posedge ref_clk) disable iff (!resetn)
    (r.state == ST_SETUP && r.cmd == CMD_MEM_WR) |=> !we_n && oe_n)
    else $error("we not low on memory write");

  // Card-to-host DMA moves data with the read strobe
  a_dma_host_strobe: assert property (@(posedge ref_clk) disable iff (!resetn)
    (r.state == ST_SETUP && r.cmd == CMD_DMA_TO_HOST) |=> !io_read_strobe_n && io_write_strobe_n)
    else $error("wrong strobe on dma to host");

  // Host-to-card DMA moves data with the write strobe
  a_dma_card_strobe: assert property (@(posedge ref_clk) disable iff (!resetn)
    (r.state == ST_SETUP && r.cmd == CMD_DMA_TO_CARD) |=> !io_write_strobe_n && io_read_strobe_n)
    else $error("wrong strobe on dma to card");

  // The two I/O strobes never overlap
  a_io_exclusive: assert property (@(posedge ref_clk) disable iff (!resetn)
    !(!io_read_strobe_n && !io_write_strobe_n))
    else $error("both io strobes low");

  // A held card reset keeps the sequencer idle
  a_reset_hold: assert property (@(posedge ref_clk) disable iff (!resetn)
    (cardResetReq && r.state == ST_IDLE) |=> r.state == ST_IDLE)
    else $error("cycle started during card reset");

  // Voltage code follows the synchronised sense pair
  a_voltage_follow: assert property (@(posedge ref_clk) disable iff (!resetn)
    cardVoltage == $past(vsSync1))
    else $error("voltage code not following sense pins");

  // Port width taken from the synchronised pin at strobe start
  a_wide_sample: assert property (@(posedge ref_clk) disable iff (!resetn)
    (r.state == ST_SETUP && (r.cmd == CMD_IO_RD || r.cmd == CMD_IO_WR))
    |=> wideXfer == $past(r.wpSync[1]))
    else $error("port width not sampled at strobe start");

  // Select is back high when done pulses
  a_reg_release: assert property (@(posedge ref_clk) disable iff (!resetn)
    done |-> reg_n)
    else $error("select still low at done");

  // Main scenarios
  c_mem_read: cover property (@(posedge ref_clk) disable iff (!resetn) !oe_n ##[1:20] done);
  c_wait: cover property (@(posedge ref_clk) disable iff (!resetn) r.waitSync[1] && !oe_n);
  c_bytes: cover property (@(posedge ref_clk) disable iff (!resetn) $rose(r.secondByte));
  c_dma_tc: cover property (@(posedge ref_clk) disable iff (!resetn) !oe_n && !io_read_strobe_n);
  c_dma_rd_tc: cover property (@(posedge ref_clk) disable iff (!resetn) !we_n && !io_write_strobe_n);
endmodule

/* verilog/card_ctl_pkg.sv */
/*
  Constants and types for the 16-bit card socket control sequencer.
  Assumes a 10 MHz ref_clk and a card whose pins are synchronised in the sequencer.
*/
// Summary of operation
// - Output enable goes low during host memory reads.
// - Output enable doubles as terminal count on the last DMA write item.
// - Attribute select high for common memory; low for attribute or I/O space.
// - Attribute select low as DMA acknowledge alongside I/O strobes.
// - Card reset output forces a hard card reset.
// - Both voltage-sense lines together give the card's operating voltage.
// - Cycle is never completed while the card holds wait active.
// - Write enable strobes write data into memory cards.
// - Write enable doubles as terminal count on the last DMA read item.
// - Card-to-host DMA uses the I/O read strobe.
// - Host-to-card DMA uses the I/O write strobe.
package card_ctl_pkg;
  localparam logic [2:0] CMD_MEM_RD = 3'h0;
  localparam logic [2:0] CMD_MEM_WR = 3'h1;
  localparam logic [2:0] CMD_IO_RD = 3'h2;
  localparam logic [2:0] CMD_IO_WR = 3'h3;
  localparam logic [2:0] CMD_DMA_TO_HOST = 3'h4;
  localparam logic [2:0] CMD_DMA_TO_CARD = 3'h5;
  // Strobe width: least 300 ns, rounded up at 100 ns clock
  localparam int STROBE_NS = 300;
  localparam int CLK_NS = 100;
  localparam logic [3:0] STROBE_CYC = 4'((STROBE_NS + CLK_NS - 1) / CLK_NS);
  // Voltage sense decode (sense b, sense a), pins low when grounded on the card
  localparam logic [1:0] VS_5V = 2'h3;
  localparam logic [1:0] VS_3V3 = 2'h2;
  localparam logic [1:0] VS_XV = 2'h1;
  localparam logic [1:0] VS_LOW = 2'h0;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SETUP = 2'b01,
    ST_STROBE = 2'b10,
    ST_DONE = 2'b11
  } state_t;
  typedef struct packed {
    state_t state;
    logic [3:0] count;
    logic [2:0] cmd;
    logic last;
    logic wide;
    logic secondByte;
    logic [1:0] waitSync;
    logic [1:0] readySync;
    logic [1:0] wpSync;
    logic oe_n;
    logic we_n;
    logic reg_n;
    logic io_read_strobe_n_n;
    logic io_write_strobe_n_n;
    logic byteHigh;
    logic done;
    logic [1:0] vsense;
  } ctl_t;
endpackage

/* tb/card_model.sv */
/*
  Behavioural 16-bit card: wait states, ready or interrupt, port width, voltage sense.
  Assumes the bench sets its behaviour through the control inputs.
*/
`timescale 1ns/10ps
module card_model (
  // Clock and socket strobes
  input wire logic ref_clk,
  input wire logic anyStrobe,
  // Behaviour controls
  input wire logic ioMode,
  input wire logic wideSel,
  input wire logic memBusy,
  input wire logic irqReq,
  input wire logic [7:0] waitLen,
  input wire logic [1:0] vsel,
  // Card pins
  output logic wait_n,
  output logic card_irq_n,
  output logic wp_pin,
  output logic voltage_sense_a,
  output logic voltage_sense_b
);
  logic [7:0] waitCnt = 8'h00;
  always @(posedge ref_clk) begin
    waitCnt <= anyStrobe ? waitCnt + 8'(waitCnt != 8'hff) : 8'h00;
  end
  // Stretch every strobe by waitLen cycles
  assign wait_n = !(anyStrobe && waitCnt < waitLen);
  assign card_irq_n = ioMode ? !irqReq : !memBusy;
  assign wp_pin = wideSel;
  assign {voltage_sense_b, voltage_sense_a} = vsel;
endmodule

/* tb/card_socket_ctl_test.sv */
/*
  Self-checking bench for the socket sequencer with a card model.
  Assumes done six cycles after a taken start of a known command, ten for narrow I/O.
*/
`timescale 1ns/10ps
module card_socket_ctl_test;
  import card_ctl_pkg::*;
  logic ref_clk = 0, resetn = 0, start = 0, lastItem = 0, ioMode = 0, cardResetReq = 0;
  logic [2:0] cmd = 0;
  logic wideSel = 1, memBusy = 0, irqReq = 0, hiSeen, anyStrobe;
  logic [7:0] waitLen = 0;
  logic [1:0] vsel = 3, cardVoltage;
  logic busy, done, wideXfer, byteHigh, cardReady, cardIrq, writeProtect, dmaRequest;
  logic oe_n, we_n, reg_n, io_read_strobe_n, io_write_strobe_n, cardReset;
  logic wait_n, card_irq_n, wp_pin, voltage_sense_a, voltage_sense_b;
  logic [19:0] cnt;
  int failures = 0, total_checks = 0, seed = 32'h40cf, n;
  assign anyStrobe = !(oe_n & we_n & io_read_strobe_n & io_write_strobe_n);
  card_socket_ctl card_socket_ctl_i (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .start(start),
    .cmd(cmd),
    .lastItem(lastItem),
    .ioMode(ioMode),
    .cardResetReq(cardResetReq),
    .busy(busy),
    .done(done),
    .wideXfer(wideXfer),
    .byteHigh(byteHigh),
    .cardReady(cardReady),
    .cardIrq(cardIrq),
    .writeProtect(writeProtect),
    .dmaRequest(dmaRequest),
    .cardVoltage(cardVoltage),
    .oe_n(oe_n),
    .we_n(we_n),
    .reg_n(reg_n),
    .io_read_strobe_n(io_read_strobe_n),
    .io_write_strobe_n(io_write_strobe_n),
    .cardReset(cardReset),
    .wait_n(wait_n),
    .card_irq_n(card_irq_n),
    .wp_pin(wp_pin),
    .voltage_sense_a(voltage_sense_a),
    .voltage_sense_b(voltage_sense_b)
  );
  card_model card_model_i (
    .ref_clk(ref_clk),
    .anyStrobe(anyStrobe),
    .ioMode(ioMode),
    .wideSel(wideSel),
    .memBusy(memBusy),
    .irqReq(irqReq),
    .waitLen(waitLen),
    .vsel(vsel),
    .wait_n(wait_n),
    .card_irq_n(card_irq_n),
    .wp_pin(wp_pin),
    .voltage_sense_a(voltage_sense_a),
    .voltage_sense_b(voltage_sense_b)
  );
  initial forever #50 ref_clk = ~ref_clk;
  task chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      failures++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task conclude;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Low cycles of {oe, we, ioRead, ioWrite, attrSelect}
  function logic [19:0] expect_cnt(input logic [2:0] c, input logic l, input logic nar);
    logic [3:0] s;
    logic [3:0] r;
    s = nar ? 4'h6 : 4'h3;
    r = nar ? 4'h9 : 4'h5;
    case (c)
      CMD_MEM_RD: return 20'h3_0000;
      CMD_MEM_WR: return 20'h0_3000;
      CMD_IO_RD: return {8'h00, s, 4'h0, r};
      CMD_IO_WR: return {12'h000, s, r};
      CMD_DMA_TO_HOST: return {l ? 4'h3 : 4'h0, 16'h0305};
      CMD_DMA_TO_CARD: return {4'h0, l ? 4'h3 : 4'h0, 12'h035};
      default: return 20'h0_0000;
    endcase
  endfunction
  task run(input logic [2:0] c, input logic l, input logic io);
    @(negedge ref_clk);
    cnt = 0;
    hiSeen = 0;
    n = 0;
    cmd = c;
    lastItem = l;
    ioMode = io;
    start = 1;
    while (n < 60) begin
      @(negedge ref_clk);
      start = 0;
      n++;
      cnt += {4'(!oe_n), 4'(!we_n), 4'(!io_read_strobe_n), 4'(!io_write_strobe_n), 4'(!reg_n)};
      hiSeen |= byteHigh;
      if (done === 1'b1) break;
    end
  endtask
  initial begin
    repeat (12) @(negedge ref_clk);
    resetn = 1;
    for (int c = 0; c < 8; c++) begin
      run(3'(c), 1'($random(seed)), c inside {[2:5]});
      if (c < 6) chk({cnt, n[7:0]}, {expect_cnt(3'(c), lastItem, 0), 8'h06});
      else chk(32'(cnt[19:4]), 32'h0000_0000);
    end
    wideSel = 0;
    for (int c = 2; c < 4; c++) begin
      run(3'(c), 0, 1);
      chk({cnt, n[7:0], hiSeen, wideXfer}, {expect_cnt(3'(c), 0, 1), 8'h0a, 2'b10});
    end
    wideSel = 1;
    waitLen = 8'(4 + ($random(seed) & 3));
    run(CMD_MEM_RD, 0, 0);
    chk({n > 6, cnt[19:16] > 4'h3}, 2'b11);
    waitLen = 0;
    @(negedge ref_clk);
    cardResetReq = 1;
    start = 1;
    repeat (8) @(negedge ref_clk);
    chk({cardReset, busy, oe_n}, 3'b101);
    start = 0;
    cardResetReq = 0;
    for (int v = 0; v < 4; v++) begin
      vsel = 2'(v ^ $random(seed));
      repeat (4) @(negedge ref_clk);
      chk(cardVoltage, vsel);
    end
    ioMode = 1;
    irqReq = 1;
    repeat (4) @(negedge ref_clk);
    chk({cardIrq, writeProtect, dmaRequest}, 3'b101);
    irqReq = 0;
    ioMode = 0;
    memBusy = 1;
    repeat (4) @(negedge ref_clk);
    chk({cardReady, cardIrq, writeProtect}, 3'b001);
    conclude;
  end
  initial begin
    #(100 * 3000);
    failures++;
    conclude;
  end
endmodule
